// ==== motion_flags_bank.sv ====
// Purpose: Latched event register, live status register and event masks
// Assumes: Register port strobes are single-cycle and synchronous to clock
// Notes: Reads answer one cycle after the strobe; events read clear on that edge
`timescale 1ns/10ps
`include "motion_flags_map.svh"

module motion_flags_bank
#(
  parameter int POS_W = 32,
  parameter int VEL_W = 32
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register access port
  input wire logic reg_select,
  input wire logic reg_write,
  input wire motion_flags_pkg::reg_addr_t reg_addr,
  input wire motion_flags_pkg::word_t reg_wdata,
  output motion_flags_pkg::word_t reg_rdata,
  output logic reg_rvalid,
  // Ramp generator state
  input wire logic signed [POS_W-1:0] actual_position,
  input wire logic signed [POS_W-1:0] target_position,
  input wire logic signed [POS_W-1:0] compare_position,
  input wire logic signed [VEL_W-1:0] actual_velocity,
  input wire logic signed [VEL_W-1:0] maximum_velocity,
  input wire logic signed [VEL_W-1:0] actual_acceleration,
  // Switches and homing
  input wire logic left_switch_active,
  input wire logic right_switch_active,
  input wire logic left_soft_limit_active,
  input wire logic right_soft_limit_active,
  input wire logic home_ref_level,
  input wire logic home_expected_level,
  // Incremental encoder
  input wire logic signed [POS_W-1:0] encoder_position,
  input wire logic [POS_W-1:0] mismatch_limit,
  input wire logic [POS_W-1:0] encoder_position_deviation,
  input wire logic [POS_W-1:0] closed_loop_tolerance,
  input wire logic signed [VEL_W-1:0] encoder_velocity,
  input wire logic index_active,
  input wire logic capture_strobe,
  // Closed loop
  input wire logic commutation_angle_at_max,
  // Serial encoder
  input wire logic serial_multi_cycle_fail,
  input wire logic serial_value_jump,
  input wire logic serial_config_done,
  input wire logic serial_request,
  input wire logic remote_flags_valid,
  input wire motion_flags_pkg::remote_flags_t remote_encoder_flags,
  // Flag outputs
  output logic multi_cycle_fail_flag,
  output logic interrupt_output
);
  import motion_flags_pkg::*;

  // ****************************************
  // State and live conditions
  // ****************************************
  bank_state_t state_reg;
  bank_state_t state_next;
  word_t live_word;
  word_t status_word;
  word_t level_cond;
  word_t pulse_cond;
  word_t event_set;
  logic read_events;
  logic write_protect;
  logic write_irq_select;
  logic remote_rising;
  remote_flags_t remote_base;
  logic read_any;
  word_t read_word;

  // ****************************************
  // Constants
  // ****************************************
  localparam int WORD_W = $bits(word_t);
  localparam word_t EVENT_BITS = `EVENTS_IMPLEMENTED;

  status_flag_compute
  #(
    .POS_W(POS_W),
    .VEL_W(VEL_W)
  )
  u_status
  (
    .actual_position(actual_position),
    .target_position(target_position),
    .compare_position(compare_position),
    .actual_velocity(actual_velocity),
    .maximum_velocity(maximum_velocity),
    .actual_acceleration(actual_acceleration),
    .left_switch_active(left_switch_active),
    .right_switch_active(right_switch_active),
    .left_soft_limit_active(left_soft_limit_active),
    .right_soft_limit_active(right_soft_limit_active),
    .home_ref_level(home_ref_level),
    .home_expected_level(home_expected_level),
    .encoder_position(encoder_position),
    .mismatch_limit(mismatch_limit),
    .encoder_position_deviation(encoder_position_deviation),
    .closed_loop_tolerance(closed_loop_tolerance),
    .index_active(index_active),
    .live_word(live_word)
  );

  // ****************************************
  // Register port decode
  // ****************************************
  always_comb
  begin
    read_any = reg_select && !reg_write;
    read_events = read_any && (reg_addr == `ADDR_EVENTS);
    write_protect = reg_select && reg_write && (reg_addr == `ADDR_EVENT_PROTECT);
    write_irq_select = reg_select && reg_write && (reg_addr == `ADDR_IRQ_SELECT);
  end

  // ****************************************
  // Full status word
  // ****************************************
  always_comb
  begin
    status_word = live_word;
    status_word[`ST_CAPTURE] = capture_strobe;
    status_word[`ST_VALUE_JUMP] = state_reg.value_jump;
    status_word[`ST_REMOTE_LSB +: 4] = state_reg.remote_flags;
  end

  // ****************************************
  // Event sources
  // ****************************************
  always_comb
  begin
    level_cond = `RESET_WORD;
    level_cond[`EV_MISMATCH] = live_word[`ST_MISMATCH];
    level_cond[`EV_INDEX] = index_active;
    level_cond[`EV_STANDSTILL] = encoder_velocity == '0;
    level_cond[`EV_ANGLE_MAX] = commutation_angle_at_max;
    level_cond[`EV_INNER_LIMIT] = live_word[`ST_WITHIN_TOL];
  end

  // ****************************************
  // Pulse event sources
  // ****************************************
  always_comb
  begin
    // A request in the same cycle empties the held flags before the new report
    remote_base = serial_request ? `RESET_REMOTE : state_reg.remote_flags;
    remote_rising = remote_flags_valid && |(remote_encoder_flags & ~remote_base);
    pulse_cond = `RESET_WORD;
    pulse_cond[`EV_CAPTURE] = capture_strobe;
    pulse_cond[`EV_SERIAL_FAULT] = serial_multi_cycle_fail || serial_value_jump;
    pulse_cond[`EV_SERIAL_CONFIG] = serial_config_done;
    pulse_cond[`EV_REMOTE_FLAG] = remote_rising;
  end

  // Level sources fire on their rising edge, pulse sources every cycle they are high
  genvar gi;
  generate
    for (gi = 0; gi < WORD_W; gi++)
    begin : g_event_set
      if (EVENT_BITS[gi])
      begin : g_used
        assign event_set[gi] = (level_cond[gi] && !state_reg.level_prev[gi])
          || pulse_cond[gi];
      end
      else
      begin : g_reserved
        assign event_set[gi] = 1'b0;
      end
    end
  endgenerate

  // ****************************************
  // Read data select
  // ****************************************
  always_comb
  begin
    case (reg_addr)
      `ADDR_EVENTS:
      begin
        read_word = state_reg.events & `EVENTS_IMPLEMENTED;
      end
      `ADDR_STATUS:
      begin
        read_word = status_word;
      end
      `ADDR_EVENT_PROTECT:
      begin
        read_word = state_reg.protect;
      end
      `ADDR_IRQ_SELECT:
      begin
        read_word = state_reg.irq_select;
      end
      default:
      begin
        read_word = `RESET_WORD;
      end
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    state_next.level_prev = level_cond;
    state_next.rvalid = read_any;
    state_next.rdata = read_any ? read_word : `RESET_WORD;
    if (write_protect)
    begin
      state_next.protect = reg_wdata;
    end
    if (write_irq_select)
    begin
      state_next.irq_select = reg_wdata;
    end
    // A set in the clearing cycle survives the read
    if (read_events)
    begin
      state_next.events = (state_reg.events & state_reg.protect) | event_set;
    end
    else
    begin
      state_next.events = state_reg.events | event_set;
    end
    // Serial flags restart with each transfer request; a new report wins
    if (serial_request)
    begin
      state_next.remote_flags = `RESET_REMOTE;
      state_next.value_jump = 1'b0;
      state_next.multi_cycle_fail = 1'b0;
    end
    if (remote_flags_valid)
    begin
      state_next.remote_flags = remote_encoder_flags;
    end
    if (serial_value_jump)
    begin
      state_next.value_jump = 1'b1;
    end
    if (serial_multi_cycle_fail)
    begin
      state_next.multi_cycle_fail = 1'b1;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state_reg.events <= `RESET_EVENTS;
      state_reg.protect <= `RESET_PROTECT;
      state_reg.irq_select <= `RESET_IRQ_SELECT;
      state_reg.rdata <= `RESET_WORD;
      state_reg.rvalid <= 1'b0;
      state_reg.level_prev <= `RESET_WORD;
      state_reg.value_jump <= 1'b0;
      state_reg.multi_cycle_fail <= 1'b0;
      state_reg.remote_flags <= `RESET_REMOTE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb
  begin
    reg_rdata = state_reg.rdata;
    reg_rvalid = state_reg.rvalid;
    multi_cycle_fail_flag = state_reg.multi_cycle_fail;
    interrupt_output = |(state_reg.events & state_reg.irq_select & `EVENTS_IMPLEMENTED);
  end

endmodule

// ==== motion_flags_map.svh ====
// Purpose: Addresses, bit positions and reset values of the event and status flag bank
// Assumes: Included by the bank modules by bare name
// Notes: Definitions only
//
// Summary of operation
// - Bit 18 sets on position mismatch beyond limit
// - Bit 19 sets when index event activates
// - Bit 20 sets on new encoder capture
// - Bit 21 sets on serial evaluation fault
// - Bit 23 sets on serial configuration received
// - Bit 24 sets when remote flag sets
// - Bit 26 sets when encoder velocity reaches zero
// - Bits 27/28: angle maximum, deviation inner limit
// - Bit 31 sets after reset
// - Status 0/1: position equals target/compare
// - Status 2: velocity equals maximum magnitude
// - Status 4:3 velocity state zero/positive/negative
// - Status 6:5 ramp state zero/accelerating/decelerating
// - Status 7-10: stop switches and soft limits
// - Status 12: home level differs from expected
// - Status 14 mismatch out of range, 15 index
// - Status 16: capture register rewritten
// - Status 17 value jump; separate multi-cycle flag
// - Status 19: deviation below closed-loop tolerance
// - Status 23:20 remote flags, cleared on request
// - Reserved event and status bits read as zero; both mask registers read back all 32 bits as written
// - Event read clears unprotected bits
// - Interrupt when any enabled event active
`ifndef MOTION_FLAGS_MAP_SVH
`define MOTION_FLAGS_MAP_SVH

// ****************************************
// Register addresses
// ****************************************
`define ADDR_W 7
`define ADDR_EVENT_PROTECT 7'h0C
`define ADDR_IRQ_SELECT 7'h0D
`define ADDR_EVENTS 7'h0E
`define ADDR_STATUS 7'h0F

// ****************************************
// Reset values
// ****************************************
`define RESET_PROTECT 32'h00000000
`define RESET_IRQ_SELECT 32'h00000000
`define RESET_EVENTS 32'h80000000
`define RESET_WORD 32'h00000000
`define RESET_REMOTE 4'h0

// ****************************************
// Event bit positions
// ****************************************
`define EV_MISMATCH 5'h12
`define EV_INDEX 5'h13
`define EV_CAPTURE 5'h14
`define EV_SERIAL_FAULT 5'h15
`define EV_SERIAL_CONFIG 5'h17
`define EV_REMOTE_FLAG 5'h18
`define EV_STANDSTILL 5'h1A
`define EV_ANGLE_MAX 5'h1B
`define EV_INNER_LIMIT 5'h1C
`define EV_RESET 5'h1F
`define EVENTS_IMPLEMENTED 32'h9DBC0000

// ****************************************
// Status bit positions
// ****************************************
`define ST_AT_TARGET 5'h00
`define ST_AT_COMPARE 5'h01
`define ST_AT_MAX_VEL 5'h02
`define ST_VEL_LSB 5'h03
`define ST_RAMP_LSB 5'h05
`define ST_LEFT_SWITCH 5'h07
`define ST_RIGHT_SWITCH 5'h08
`define ST_LEFT_SOFT 5'h09
`define ST_RIGHT_SOFT 5'h0A
`define ST_HOME_ERROR 5'h0C
`define ST_MISMATCH 5'h0E
`define ST_INDEX 5'h0F
`define ST_CAPTURE 5'h10
`define ST_VALUE_JUMP 5'h11
`define ST_WITHIN_TOL 5'h13
`define ST_REMOTE_LSB 5'h14

// ****************************************
// Field encodings
// ****************************************
`define VEL_ZERO 2'h0
`define VEL_POSITIVE 2'h1
`define VEL_NEGATIVE 2'h2
`define RAMP_CONSTANT 2'h0
`define RAMP_ACCEL 2'h1
`define RAMP_DECEL 2'h2

`endif

// ==== motion_flags_pkg.sv ====
// Purpose: Types shared by the event and status flag bank
// Assumes: Nothing beyond the map header
// Notes: Types only
package motion_flags_pkg;

  typedef logic [31:0] word_t;
  typedef logic [6:0] reg_addr_t;
  typedef logic [3:0] remote_flags_t;

  typedef struct packed {
    word_t events;
    word_t protect;
    word_t irq_select;
    word_t rdata;
    logic rvalid;
    word_t level_prev;
    logic value_jump;
    logic multi_cycle_fail;
    remote_flags_t remote_flags;
  } bank_state_t;

endpackage

// ==== status_flag_compute.sv ====
// Purpose: Live status word built from the motion and encoder conditions
// Assumes: All inputs synchronous to the bank clock
// Notes: Purely combinational; the bank registers the result on a read
`timescale 1ns/10ps
`include "motion_flags_map.svh"

module status_flag_compute
#(
  parameter int POS_W = 32,
  parameter int VEL_W = 32
)
(
  // Ramp generator state
  input wire logic signed [POS_W-1:0] actual_position,
  input wire logic signed [POS_W-1:0] target_position,
  input wire logic signed [POS_W-1:0] compare_position,
  input wire logic signed [VEL_W-1:0] actual_velocity,
  input wire logic signed [VEL_W-1:0] maximum_velocity,
  input wire logic signed [VEL_W-1:0] actual_acceleration,
  // Switches and homing
  input wire logic left_switch_active,
  input wire logic right_switch_active,
  input wire logic left_soft_limit_active,
  input wire logic right_soft_limit_active,
  input wire logic home_ref_level,
  input wire logic home_expected_level,
  // Encoder
  input wire logic signed [POS_W-1:0] encoder_position,
  input wire logic [POS_W-1:0] mismatch_limit,
  input wire logic [POS_W-1:0] encoder_position_deviation,
  input wire logic [POS_W-1:0] closed_loop_tolerance,
  input wire logic index_active,
  // Result
  output motion_flags_pkg::word_t live_word
);
  import motion_flags_pkg::*;

  logic signed [POS_W:0] pos_diff;
  logic [POS_W:0] pos_diff_abs;
  logic [VEL_W-1:0] maximum_velocity_abs;
  logic [1:0] vel_state;
  logic [1:0] ramp_state;

  always_comb
  begin
    pos_diff = {actual_position[POS_W-1], actual_position}
      - {encoder_position[POS_W-1], encoder_position};
    pos_diff_abs = pos_diff[POS_W] ? (POS_W+1)'(-pos_diff) : pos_diff;
    maximum_velocity_abs = maximum_velocity[VEL_W-1] ? VEL_W'(-maximum_velocity) : maximum_velocity;
    if (actual_velocity == '0)
      vel_state = `VEL_ZERO;
    else if (actual_velocity[VEL_W-1])
      vel_state = `VEL_NEGATIVE;
    else
      vel_state = `VEL_POSITIVE;
    if (actual_acceleration == '0)
      ramp_state = `RAMP_CONSTANT;
    else if (actual_acceleration[VEL_W-1])
      ramp_state = `RAMP_DECEL;
    else
      ramp_state = `RAMP_ACCEL;
    live_word = `RESET_WORD;
    live_word[`ST_AT_TARGET] = actual_position == target_position;
    live_word[`ST_AT_COMPARE] = actual_position == compare_position;
    live_word[`ST_AT_MAX_VEL] = actual_velocity == $signed(maximum_velocity_abs);
    live_word[`ST_VEL_LSB +: 2] = vel_state;
    live_word[`ST_RAMP_LSB +: 2] = ramp_state;
    live_word[`ST_LEFT_SWITCH] = left_switch_active;
    live_word[`ST_RIGHT_SWITCH] = right_switch_active;
    live_word[`ST_LEFT_SOFT] = left_soft_limit_active;
    live_word[`ST_RIGHT_SOFT] = right_soft_limit_active;
    live_word[`ST_HOME_ERROR] = home_ref_level != home_expected_level;
    live_word[`ST_MISMATCH] = pos_diff_abs > {1'b0, mismatch_limit};
    live_word[`ST_INDEX] = index_active;
    live_word[`ST_WITHIN_TOL] = encoder_position_deviation < closed_loop_tolerance;
  end

endmodule

// ==== flags_chk.sv ====
// Purpose: Concurrent checks on the event and status flag bank ports
// Assumes: Bound to motion_flags_bank, one clock domain
// Notes: Status checks compare against the inputs seen at the read edge
`timescale 1ns/10ps

module flags_chk
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register access port
  input wire logic reg_select,
  input wire logic reg_write,
  input wire motion_flags_pkg::reg_addr_t reg_addr,
  input wire motion_flags_pkg::word_t reg_rdata,
  input wire logic reg_rvalid,
  // Conditions
  input wire logic left_switch_active,
  input wire logic home_ref_level,
  input wire logic home_expected_level,
  input wire logic index_active,
  input wire logic capture_strobe,
  input wire logic serial_multi_cycle_fail,
  input wire logic serial_request,
  // Flag outputs
  input wire logic multi_cycle_fail_flag
);
  import motion_flags_pkg::*;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // ****************************************
  // Access steps
  // ****************************************
  sequence rd_any;
    reg_select && !reg_write;
  endsequence
  sequence rd_ev;
    rd_any ##0 reg_addr == 7'h0E;
  endsequence
  sequence rd_st;
    rd_any ##0 reg_addr == 7'h0F;
  endsequence

  a_read_answer: assert property (rd_any |=> reg_rvalid)
    else $error("read strobe got no valid");
  a_valid_only_read: assert property (!(reg_select && !reg_write) |=> !reg_rvalid)
    else $error("valid without a read");
  a_status_home: assert property (rd_st |=>
    reg_rdata[12] == ($past(home_ref_level) != $past(home_expected_level)))
    else $error("home level flag wrong");
  a_status_switch: assert property (rd_st |=> reg_rdata[7] == $past(left_switch_active))
    else $error("left switch flag wrong");
  a_status_index: assert property (rd_st |=> reg_rdata[15] == $past(index_active))
    else $error("index flag wrong");
  a_status_capture: assert property (rd_st |=> reg_rdata[16] == $past(capture_strobe))
    else $error("capture flag wrong");
  a_status_reserved: assert property (rd_st |=> (reg_rdata & 32'hFF042800) == 32'h0)
    else $error("reserved status bit set");
  a_event_reserved: assert property (rd_ev |=> (reg_rdata & 32'h6243FFFF) == 32'h0)
    else $error("reserved event bit set");
  a_capture_sticky: assert property (capture_strobe ##1 rd_ev |=> reg_rdata[20])
    else $error("capture event missing");
  a_fail_flag_set: assert property (serial_multi_cycle_fail && !serial_request |=>
    multi_cycle_fail_flag)
    else $error("multi cycle flag not set");
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the event and status flag bank
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Expected words are worked out by hand from the bit layout
`timescale 1ns/10ps

module tb_top;
  import motion_flags_pkg::*;

  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic reg_select = 1'b0, reg_write = 1'b0;
  reg_addr_t reg_addr = 7'h00;
  word_t reg_wdata = 32'h0, reg_rdata;
  logic reg_rvalid, multi_cycle_fail_flag, interrupt_output;
  logic signed [31:0] actual_position = 0, target_position = 0, compare_position = 0;
  logic signed [31:0] actual_velocity = 0, maximum_velocity = 0, actual_acceleration = 0;
  logic left_switch_active = 0, right_switch_active = 0;
  logic left_soft_limit_active = 0, right_soft_limit_active = 0;
  logic home_ref_level = 0, home_expected_level = 0, index_active = 0;
  logic signed [31:0] encoder_position = 0, encoder_velocity = 1;
  logic [31:0] mismatch_limit = 0, encoder_position_deviation = 0, closed_loop_tolerance = 0;
  logic capture_strobe = 0, commutation_angle_at_max = 0;
  logic serial_multi_cycle_fail = 0, serial_value_jump = 0, serial_config_done = 0;
  logic serial_request = 0, remote_flags_valid = 0;
  remote_flags_t remote_encoder_flags = 4'h0;
  int failures = 0;
  int compares = 0;

  always #20 clock = ~clock;

  motion_flags_bank motion_flags_bank_i (.*);

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task step;
    @(posedge clock);
    #1;
  endtask

  task chk(input word_t seen, input word_t exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task rc(input reg_addr_t a, input word_t exp);
    reg_select = 1'b1;
    reg_write = 1'b0;
    reg_addr = a;
    step;
    chk(reg_rdata, exp);
    chk({31'h0, reg_rvalid}, 32'h1);
    reg_select = 1'b0;
    step;
    chk({31'h0, reg_rvalid}, 32'h0);
  endtask

  task wr(input reg_addr_t a, input word_t d);
    reg_select = 1'b1;
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step;
    reg_select = 1'b0;
    reg_write = 1'b0;
    step;
  endtask

  task set_case(input int ap, tp, cp, av, vm, acc, input logic [3:0] sw, input logic hr, he,
                input int ep, lim, dev, tol, input logic idx);
    actual_position = ap;
    target_position = tp;
    compare_position = cp;
    actual_velocity = av;
    maximum_velocity = vm;
    actual_acceleration = acc;
    {left_switch_active, right_switch_active} = sw[3:2];
    {left_soft_limit_active, right_soft_limit_active} = sw[1:0];
    home_ref_level = hr;
    home_expected_level = he;
    encoder_position = ep;
    mismatch_limit = lim;
    encoder_position_deviation = dev;
    closed_loop_tolerance = tol;
    index_active = idx;
    step;
  endtask

  task close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    repeat (8) step;
    rst_b = 1'b1;
    rc(7'h0E, 32'h80000000);
    rc(7'h0E, 32'h00000000);
    $display("test reset done");
    set_case(10, 10, 11, 7, -7, -2, 4'b1001, 1, 0, 20, 5, 3, 4, 1);
    rc(7'h0F, 32'h0008D4CD);
    set_case(3, 4, 3, -1, 9, 6, 4'b0110, 0, 0, 3, 0, 4, 4, 0);
    rc(7'h0F, 32'h00000332);
    rc(7'h0E, 32'h100C0000);
    rc(7'h0E, 32'h00000000);
    $display("test status done");
    encoder_velocity = 0;
    commutation_angle_at_max = 1'b1;
    serial_multi_cycle_fail = 1'b1;
    serial_config_done = 1'b1;
    remote_flags_valid = 1'b1;
    remote_encoder_flags = 4'h5;
    step;
    serial_multi_cycle_fail = 1'b0;
    serial_config_done = 1'b0;
    remote_flags_valid = 1'b0;
    capture_strobe = 1'b1;
    step;
    capture_strobe = 1'b0;
    rc(7'h0E, 32'h0DB00000);
    rc(7'h0F, 32'h00500332);
    chk({31'h0, multi_cycle_fail_flag}, 32'h1);
    serial_request = 1'b1;
    commutation_angle_at_max = 1'b0;
    step;
    serial_request = 1'b0;
    rc(7'h0F, 32'h00000332);
    chk({31'h0, multi_cycle_fail_flag}, 32'h0);
    serial_value_jump = 1'b1;
    step;
    serial_value_jump = 1'b0;
    rc(7'h0F, 32'h00020332);
    rc(7'h0E, 32'h00200000);
    $display("test serial done");
    wr(7'h0C, 32'h00080000);
    index_active = 1'b1;
    step;
    rc(7'h0E, 32'h00080000);
    rc(7'h0E, 32'h00080000);
    wr(7'h0E, 32'hFFFFFFFF);
    rc(7'h0E, 32'h00080000);
    wr(7'h0D, 32'h00080000);
    chk({31'h0, interrupt_output}, 32'h1);
    rc(7'h0D, 32'h00080000);
    wr(7'h0D, 32'h00000000);
    chk({31'h0, interrupt_output}, 32'h0);
    rc(7'h20, 32'h00000000);
    $display("test masks done");
    rst_b = 1'b0;
    repeat (2) step;
    rst_b = 1'b1;
    step;
    rc(7'h0E, 32'h84080000);
    chk({31'h0, interrupt_output}, 32'h0);
    $display("test second reset done");
    close_out;
  end

  initial
  begin
    #200000;
    failures++;
    close_out;
  end
endmodule

bind motion_flags_bank flags_chk flags_chk_i (.*);
